// ==== core/tmr_consts.svh ====
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_OFS_CNT_L  8'h00
`define TMR_OFS_CNT_H  8'h04
`define TMR_OFS_CMPA_L 8'h08
`define TMR_OFS_CMPA_H 8'h0c
`define TMR_OFS_CMPB_L 8'h10
`define TMR_OFS_CMPB_H 8'h14
`define TMR_OFS_CAP_L  8'h18
`define TMR_OFS_CAP_H  8'h1c
`define TMR_OFS_CTL1   8'h20
`define TMR_OFS_CTL2   8'h24
`define TMR_OFS_CTL3   8'h28
`define TMR_OFS_FLAG   8'h2c
`define TMR_OFS_MASK   8'h30
`define TMR_OFS_POWER  8'h34
`define TMR_BOT        16'h0000
`define TMR_MAX        16'hffff
`define TMR_TOP8       16'h00ff
`define TMR_TOP9       16'h01ff
`define TMR_TOP10      16'h03ff
`define TMR_RST_POWER  1'b1
`define TMR_F_ICNC     7
`define TMR_F_ICES     6
`define TMR_F_CSRC     5
`define TMR_F_WGM3     4
`define TMR_F_WGM2     3
`define TMR_F_FOCA     7
`define TMR_F_FOCB     6
`define TMR_F_CAP      5
`define TMR_F_MB       2
`define TMR_F_MA       1
`define TMR_F_OV       0
`endif

// ==== core/tmr_pkg.sv ====
package tmr_pkg;
    typedef enum logic [1:0] {
        KIND_NORM  = 2'b00,
        KIND_CTC   = 2'b01,
        KIND_FAST  = 2'b10,
        KIND_PHASE = 2'b11
    } tmr_kind_type;
    // bit order: capture, match b, match a, overflow
    typedef logic [3:0] tmr_irq_type;
endpackage : tmr_pkg

// ==== core/tmr_core.sv ====
`timescale 1ns/1ps
`include "tmr_consts.svh"
// Notes on behaviour
// - timer idle until power-off bit cleared
// - 16-bit counter/compare/capture, 8-bit free controls
// - every request flagged and individually maskable
// - prescaler or pin clock; none selected holds
// - compare match sets flag, drives wave
// - compare writes land in buffer first
// - edge event copies counter into capture
// - optional noise filter on capture input
// - top from fixed, compare A or capture
// - compare A as top: no A PWM
// - bottom, max and top conditions detected
// - one shared high-byte staging register
// - low write loads staged high plus low
// - low read stages high byte for later
// - compare reads bypass staging register
// - force bits ctl three, mode bit3 ctl two
// - counter write beats clear or count
// - capture flag set with copy, write-one clears
module tmr_core #(
    parameter int FILT_LEN = 4
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 extClockPin,
    input  wire logic                 capturePin,
    input  wire logic                 compOut,
    input  wire tmr_pkg::tmr_irq_type irqAck,
    output tmr_pkg::tmr_irq_type      irqReq,
    output logic                      waveOutA,
    output logic                      waveOutB
);
    import tmr_pkg::*;
    logic [15:0]         counterValue;
    logic [15:0]         compareAValue;
    logic [15:0]         compareBValue;
    logic [15:0]         compareAAct;
    logic [15:0]         compareBAct;
    logic [15:0]         captureValue;
    logic [7:0]          controlOne;
    logic [7:0]          controlTwo;
    logic [7:0]          stageHigh;
    tmr_irq_type         irqFlagReg;
    tmr_irq_type         irqMaskReg;
    logic                powerOffBit;
    logic                countUp;
    logic [9:0]          prescale;
    logic                extQ;
    logic                extPrev;
    logic [FILT_LEN-1:0] capHist;
    logic                capFilt;
    logic                capQ;
    logic                capPrev;
    function automatic tmr_kind_type kind_of(input logic [3:0] m);
        case (m)
            4'h4, 4'hc: kind_of = KIND_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = KIND_FAST;
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: kind_of = KIND_PHASE;
            default: kind_of = KIND_NORM;
        endcase
    endfunction : kind_of
    // com 0 leaves the pin state alone; in pwm kinds com 1 is unused
    function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                       input tmr_kind_type k, input logic hit,
                                       input logic top, input logic up);
        wave_next = cur;
        case (k)
            KIND_NORM, KIND_CTC: begin
                if (hit && com != 2'd0)
                    wave_next = (com == 2'd1) ? ~cur : com[0];
            end
            KIND_FAST: begin
                if (com[1] && top)
                    wave_next = ~com[0];
                else if (com[1] && hit)
                    wave_next = com[0];
            end
            KIND_PHASE: begin
                if (com[1] && hit)
                    wave_next = up ? com[0] : ~com[0];
            end
            default: wave_next = cur;
        endcase
    endfunction : wave_next
    // bus decode
    wire [7:0] wd      = pwdata[7:0];
    wire       setupPh = psel & ~penable;
    wire       wrAcc   = psel & penable & pready & pwrite;
    wire       wrT     = wrAcc & ~powerOffBit;
    wire       rdSet   = setupPh & ~pwrite;
    wire aCntL  = paddr == `TMR_OFS_CNT_L;
    wire aCntH  = paddr == `TMR_OFS_CNT_H;
    wire aCmpAL = paddr == `TMR_OFS_CMPA_L;
    wire aCmpAH = paddr == `TMR_OFS_CMPA_H;
    wire aCmpBL = paddr == `TMR_OFS_CMPB_L;
    wire aCmpBH = paddr == `TMR_OFS_CMPB_H;
    wire aCapL  = paddr == `TMR_OFS_CAP_L;
    wire aCapH  = paddr == `TMR_OFS_CAP_H;
    wire aCtl1  = paddr == `TMR_OFS_CTL1;
    wire aCtl2  = paddr == `TMR_OFS_CTL2;
    wire aCtl3  = paddr == `TMR_OFS_CTL3;
    wire aFlag  = paddr == `TMR_OFS_FLAG;
    wire aMask  = paddr == `TMR_OFS_MASK;
    wire aPower = paddr == `TMR_OFS_POWER;
    wire mapped = aCntL | aCntH | aCmpAL | aCmpAH | aCmpBL | aCmpBH | aCapL | aCapH
                | aCtl1 | aCtl2 | aCtl3 | aFlag | aMask | aPower;
    // mode and top selection
    wire [3:0] wgm = {controlTwo[`TMR_F_WGM3], controlTwo[`TMR_F_WGM2],
                      controlOne[1:0]};
    tmr_kind_type kind;
    assign kind = kind_of(wgm);
    wire isPwm    = kind == KIND_FAST || kind == KIND_PHASE;
    wire isPhase  = kind == KIND_PHASE;
    wire topIsA   = wgm == 4'h4 || wgm == 4'h9 || wgm == 4'hb || wgm == 4'hf;
    wire topIsCap = wgm == 4'h8 || wgm == 4'ha || wgm == 4'hc || wgm == 4'he;
    wire [15:0] fixTop = (wgm[1:0] == 2'd1) ? `TMR_TOP8 :
                         (wgm[1:0] == 2'd2) ? `TMR_TOP9 : `TMR_TOP10;
    wire [15:0] topVal = topIsA ? compareAAct : topIsCap ? captureValue :
                         isPwm ? fixTop : `TMR_MAX;
    // clock select; prescaler runs free so taps stay aligned
    wire [2:0] cs      = controlTwo[2:0];
    wire       extRise = extQ & ~extPrev;
    wire       extFall = ~extQ & extPrev;
    wire timerTick = ~powerOffBit & ((cs == 3'd1)
                   | ((cs == 3'd2) & (&prescale[2:0]))
                   | ((cs == 3'd3) & (&prescale[5:0]))
                   | ((cs == 3'd4) & (&prescale[7:0]))
                   | ((cs == 3'd5) & (&prescale))
                   | ((cs == 3'd6) & extFall)
                   | ((cs == 3'd7) & extRise));
    // counter unit
    wire atBot = counterValue == `TMR_BOT;
    wire atMax = counterValue == `TMR_MAX;
    wire atTop = counterValue == topVal;
    wire        cntWr  = wrT & aCntL;
    wire [15:0] wrWord = {stageHigh, wd};
    wire [15:0] cntInc = counterValue + 16'h0001;
    wire [15:0] cntDec = counterValue - 16'h0001;
    wire [15:0] stepVal = isPhase ? ((countUp ? atTop : ~atBot) ? cntDec : cntInc)
                                  : (atTop ? `TMR_BOT : cntInc);
    wire [15:0] next_counter = cntWr ? wrWord :
                               timerTick ? stepVal : counterValue;
    wire next_up = ~isPhase ? 1'b1 :
                   (timerTick & ~cntWr & countUp & atTop) ? 1'b0 :
                   (timerTick & ~cntWr & ~countUp & atBot) ? 1'b1 : countUp;
    // compare units
    wire hitA = timerTick & (counterValue == compareAAct);
    wire hitB = timerTick & (counterValue == compareBAct);
    // phase-frequency kinds reload at bottom, other pwm kinds at top
    wire updEv = ~isPwm | (timerTick & ((wgm[3:1] == 3'b100) ? atBot : atTop));
    wire forceA = wrT & aCtl3 & wd[`TMR_F_FOCA] & ~isPwm;
    wire forceB = wrT & aCtl3 & wd[`TMR_F_FOCB] & ~isPwm;
    wire next_waveA = (isPwm & topIsA) ? 1'b0 :
        wave_next(waveOutA, controlOne[7:6], kind, hitA | forceA,
                  timerTick & atTop, countUp);
    wire next_waveB = wave_next(waveOutB, controlOne[5:4], kind, hitB | forceB,
                                timerTick & atTop, countUp);
    // capture unit
    wire capSrc = controlTwo[`TMR_F_CSRC] ? compOut : capturePin;
    wire capLvl = controlTwo[`TMR_F_ICNC] ? capFilt : capQ;
    wire next_capFilt = (&capHist) ? 1'b1 : (~|capHist) ? 1'b0 : capFilt;
    // capture is frozen while the capture register defines top
    wire capEv = ~powerOffBit & ~topIsCap &
                 (controlTwo[`TMR_F_ICES] ? (capLvl & ~capPrev)
                                          : (~capLvl & capPrev));
    // flags: a set in the clearing cycle survives
    wire ovEv = timerTick & (isPhase ? (atBot & ~countUp) :
                             (kind == KIND_FAST) ? atTop : atMax);
    wire [3:0] evVec  = {capEv, hitB, hitA, ovEv};
    wire [3:0] clrVec = ((wrT & aFlag) ? {wd[`TMR_F_CAP], wd[`TMR_F_MB], wd[`TMR_F_MA],
                                          wd[`TMR_F_OV]} : 4'h0) | irqAck;
    wire [3:0] next_flags = (irqFlagReg & ~clrVec) | evVec;
    // staging register and read data
    wire hiWr   = wrT & (aCntH | aCmpAH | aCmpBH | aCapH);
    wire loRdSt = rdSet & (aCntL | aCapL);
    wire [7:0] flagByte = {2'b00, irqFlagReg[3], 2'b00, irqFlagReg[2:0]};
    wire [7:0] maskByte = {2'b00, irqMaskReg[3], 2'b00, irqMaskReg[2:0]};
    wire [7:0] rdByte =
        aCntL  ? counterValue[7:0]   : aCntH  ? stageHigh :
        aCmpAL ? compareAValue[7:0]  : aCmpAH ? compareAValue[15:8] :
        aCmpBL ? compareBValue[7:0]  : aCmpBH ? compareBValue[15:8] :
        aCapL  ? captureValue[7:0]   : aCapH  ? stageHigh :
        aCtl1  ? controlOne : aCtl2 ? controlTwo :
        aFlag  ? flagByte   : aMask ? maskByte :
        aPower ? {7'h00, powerOffBit} : 8'h00;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPh;
            pslverr <= setupPh & ~mapped;
            if (rdSet)
                prdata <= {24'h00_0000, rdByte};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stageHigh <= 8'h00;
        end else if (hiWr) begin
            stageHigh <= wd;
        end else if (loRdSt) begin
            stageHigh <= aCntL ? counterValue[15:8] : captureValue[15:8];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            controlOne  <= 8'h00;
            controlTwo  <= 8'h00;
            irqMaskReg  <= 4'h0;
            powerOffBit <= `TMR_RST_POWER;
        end else begin
            if (wrT && aCtl1)
                controlOne <= wd;
            if (wrT && aCtl2)
                controlTwo <= wd;
            if (wrT && aMask)
                irqMaskReg <= {wd[`TMR_F_CAP], wd[`TMR_F_MB], wd[`TMR_F_MA], wd[`TMR_F_OV]};
            if (wrAcc && aPower)
                powerOffBit <= wd[0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            counterValue <= 16'h0000;
            countUp      <= 1'b1;
            prescale     <= 10'h000;
            extQ         <= 1'b0;
            extPrev      <= 1'b0;
        end else begin
            counterValue <= next_counter;
            countUp      <= next_up;
            prescale     <= prescale + 10'h001;
            extQ         <= extClockPin;
            extPrev      <= extQ;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            compareAValue <= 16'h0000;
            compareBValue <= 16'h0000;
            compareAAct   <= 16'h0000;
            compareBAct   <= 16'h0000;
        end else begin
            if (wrT && aCmpAL)
                compareAValue <= wrWord;
            if (wrT && aCmpBL)
                compareBValue <= wrWord;
            if (updEv) begin
                compareAAct <= compareAValue;
                compareBAct <= compareBValue;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            captureValue <= 16'h0000;
            capHist      <= '0;
            capFilt      <= 1'b0;
            capQ         <= 1'b0;
            capPrev      <= 1'b0;
        end else begin
            if (capEv)
                captureValue <= counterValue;
            else if (wrT && aCapL && topIsCap)
                captureValue <= wrWord;
            capHist <= {capHist[FILT_LEN-2:0], capSrc};
            capFilt <= next_capFilt;
            capQ    <= capSrc;
            capPrev <= capLvl;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irqFlagReg <= 4'h0;
            irqReq     <= 4'h0;
            waveOutA   <= 1'b0;
            waveOutB   <= 1'b0;
        end else begin
            irqFlagReg <= next_flags;
            irqReq     <= irqFlagReg & irqMaskReg;
            waveOutA   <= next_waveA;
            waveOutB   <= next_waveB;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence loReadSeq;
        rdSet & aCntL;
    endsequence
    sequence hiReadSeq;
        rdSet & aCntH;
    endsequence
    ovf_set_a: assert property (ovEv |=> irqFlagReg[0])
        else $error("overflow flag not set");
    mask_gate_a: assert property (irqReq == ($past(irqFlagReg) & $past(irqMaskReg)))
        else $error("irq request not flag and mask");
    power_hold_a: assert property (powerOffBit |=> $stable(counterValue))
        else $error("counter moved while powered off");
    stop_hold_a: assert property (cs == 3'd0 && !cntWr |=> $stable(counterValue))
        else $error("counter moved with no clock source");
    match_b_a: assert property (hitB |=> irqFlagReg[2])
        else $error("match b flag not set");
    buf_hold_a: assert property (isPwm && !updEv |=> $stable(compareAAct))
        else $error("active compare changed outside update");
    cap_copy_a: assert property (capEv |=> captureValue == $past(counterValue))
        else $error("capture did not copy counter");
    cap_flag_a: assert property (capEv |=>
                                 irqFlagReg[3] && captureValue == $past(counterValue))
        else $error("capture flag not set with copy");
    pwm_a_off_a: assert property (isPwm && topIsA |=> !waveOutA)
        else $error("channel a pwm while a is top");
    cnt_wr_a: assert property (cntWr |=> counterValue == $past(wrWord))
        else $error("counter write lost");
    cmp_rd_a: assert property (rdSet && (aCmpAL || aCmpAH) |=> $stable(stageHigh))
        else $error("compare read touched staging");
    hi_wr_a: assert property (wrT && aCmpAH |=> $stable(compareAValue))
        else $error("high write changed target");
    lo_hi_rd_a: assert property (loReadSeq ##3 hiReadSeq |=>
                                 prdata == {24'h00_0000, 8'($past(counterValue, 4) >> 8)})
        else $error("high read not the staged byte");
endmodule : tmr_core

// ==== tb/tmr_host_model.sv ====
`timescale 1ns/1ps
module tmr_host_model (
    input  wire logic        ref_clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic [7:0]       paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      pwdata
);
    initial begin
        paddr   = 8'h00;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        pwdata  = 32'h0;
    end

    // one byte access; the request holds until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic err);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q   = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // both bytes back to back, nothing else may touch the shared stage between
    task automatic wr16(input logic [7:0] a, input logic [15:0] x);
        logic [7:0] q;
        logic       e;
        xfer(1'b1, a + 8'h04, x[15:8], q, e);
        xfer(1'b1, a, x[7:0], q, e);
    endtask : wr16

    task automatic rd16(input logic [7:0] a, output logic [15:0] x);
        logic e;
        xfer(1'b0, a, 8'h00, x[7:0], e);
        xfer(1'b0, a + 8'h04, 8'h00, x[15:8], e);
    endtask : rd16
endmodule : tmr_host_model

// ==== tb/sixteen_bit_timer_core_tb_top.sv ====
`timescale 1ns/1ps
`include "tmr_consts.svh"
module sixteen_bit_timer_core_tb_top;
    import tmr_pkg::*;
    logic        ref_clk;
    logic        nrst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        extClockPin;
    logic        capturePin;
    logic        compOut;
    tmr_irq_type irqAck;
    tmr_irq_type irqReq;
    logic        waveOutA;
    logic        waveOutB;
    logic [7:0]  q8;
    logic        e1;
    logic [15:0] v;
    int          nErrors = 0;
    int          comparisons = 0;

    tmr_core #(.FILT_LEN(4)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .extClockPin(extClockPin),
        .capturePin(capturePin), .compOut(compOut), .irqAck(irqAck), .irqReq(irqReq),
        .waveOutA(waveOutA), .waveOutB(waveOutB));
    tmr_host_model i_host (.ref_clk(ref_clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic check(input string w, input logic [15:0] x, input logic [15:0] got);
        comparisons++;
        if (got !== x) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", w, x, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, q8, e1);
    endtask : wr

    task automatic rc(input string w, input logic [7:0] a, input logic [7:0] x);
        i_host.xfer(1'b0, a, 8'h00, q8, e1);
        check(w, {8'h00, x}, {8'h00, q8});
    endtask : rc

    task automatic rc16(input string w, input logic [7:0] a, input logic [15:0] x);
        i_host.rd16(a, v);
        check(w, x, v);
    endtask : rc16

    task automatic endSim;
        $display("checks %0d mismatches %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : endSim

    // whole run is under two thousand cycles
    initial begin
        tick(20000);
        nErrors++;
        $display("watchdog expired");
        endSim();
    end

    initial begin
        nrst        = 1'b0;
        extClockPin = 1'b0;
        capturePin  = 1'b0;
        compOut     = 1'b0;
        irqAck      = 4'h0;
        tick(6);
        nrst <= 1'b1;
        rc("power", `TMR_OFS_POWER, 8'h01);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h1234);
        rc16("cnt off", `TMR_OFS_CNT_L, 16'h0000);
        i_host.xfer(1'b0, 8'h38, 8'h00, q8, e1);
        check("slverr", 16'h0001, {15'h0, e1});
        wr(`TMR_OFS_POWER, 8'h00);
        rc("power", `TMR_OFS_POWER, 8'h00);
        $display("test power done");
        wr(`TMR_OFS_CTL1, 8'hf3);
        wr(`TMR_OFS_CTL2, 8'hf8);
        wr(`TMR_OFS_MASK, 8'h27);
        rc("ctl1", `TMR_OFS_CTL1, 8'hf3);
        rc("ctl2", `TMR_OFS_CTL2, 8'hf8);
        rc("mask", `TMR_OFS_MASK, 8'h27);
        wr(`TMR_OFS_CTL1, 8'h00);
        wr(`TMR_OFS_CTL2, 8'h00);
        $display("test controls done");
        i_host.wr16(`TMR_OFS_CNT_L, 16'h1234);
        rc16("cnt", `TMR_OFS_CNT_L, 16'h1234);
        wr(`TMR_OFS_CNT_H, 8'h56);
        wr(`TMR_OFS_CMPA_L, 8'h9a);
        rc16("cnt hi only", `TMR_OFS_CNT_L, 16'h1234);
        rc("cnt lo", `TMR_OFS_CNT_L, 8'h34);
        rc("cmpa lo", `TMR_OFS_CMPA_L, 8'h9a);
        rc("cmpa hi", `TMR_OFS_CMPA_H, 8'h56);
        rc("stage", `TMR_OFS_CNT_H, 8'h12);
        $display("test staging done");
        tick(20);
        rc16("cnt held", `TMR_OFS_CNT_L, 16'h1234);
        wr(`TMR_OFS_CTL2, 8'h01);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h8000);
        wr(`TMR_OFS_CTL2, 8'h00);
        i_host.rd16(`TMR_OFS_CNT_L, v);
        check("cnt run", 16'h0001, {15'h0, v > 16'h8000 && v <= 16'h8008});
        i_host.wr16(`TMR_OFS_CNT_L, 16'h0000);
        wr(`TMR_OFS_CTL2, 8'h07);
        repeat (4) begin
            extClockPin <= 1'b1;
            tick(3);
            extClockPin <= 1'b0;
            tick(3);
        end
        wr(`TMR_OFS_CTL2, 8'h00);
        rc16("cnt ext", `TMR_OFS_CNT_L, 16'h0004);
        $display("test counting done");
        i_host.wr16(`TMR_OFS_CNT_L, 16'hfff0);
        i_host.wr16(`TMR_OFS_CMPA_L, 16'hfff8);
        i_host.wr16(`TMR_OFS_CMPB_L, 16'h0004);
        wr(`TMR_OFS_MASK, 8'h00);
        wr(`TMR_OFS_FLAG, 8'h27);
        wr(`TMR_OFS_CTL2, 8'h01);
        tick(40);
        wr(`TMR_OFS_CTL2, 8'h00);
        rc("flags", `TMR_OFS_FLAG, 8'h07);
        check("irq masked", 16'h0000, {12'h0, irqReq});
        wr(`TMR_OFS_MASK, 8'h02);
        tick(2);
        check("irq a", 16'h0002, {12'h0, irqReq});
        irqAck <= 4'h2;
        tick(1);
        irqAck <= 4'h0;
        tick(2);
        rc("ack clr", `TMR_OFS_FLAG, 8'h05);
        wr(`TMR_OFS_FLAG, 8'h05);
        rc("w1 clr", `TMR_OFS_FLAG, 8'h00);
        $display("test flags done");
        wr(`TMR_OFS_CTL2, 8'h40);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h0777);
        wr(`TMR_OFS_FLAG, 8'h20);
        capturePin <= 1'b1;
        tick(5);
        rc("cap flag", `TMR_OFS_FLAG, 8'h20);
        rc16("cap", `TMR_OFS_CAP_L, 16'h0777);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h0888);
        wr(`TMR_OFS_FLAG, 8'h20);
        capturePin <= 1'b0;
        tick(5);
        rc("cap fall", `TMR_OFS_FLAG, 8'h00);
        wr(`TMR_OFS_CTL2, 8'h60);
        wr(`TMR_OFS_FLAG, 8'h20);
        compOut <= 1'b1;
        tick(5);
        rc("cmp flag", `TMR_OFS_FLAG, 8'h20);
        rc16("cap cmp", `TMR_OFS_CAP_L, 16'h0888);
        wr(`TMR_OFS_CTL2, 8'hc0);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h0999);
        wr(`TMR_OFS_FLAG, 8'h20);
        // spike shorter than the filter length must be swallowed
        capturePin <= 1'b1;
        tick(2);
        capturePin <= 1'b0;
        tick(10);
        rc("spike", `TMR_OFS_FLAG, 8'h00);
        capturePin <= 1'b1;
        tick(12);
        rc("filt flag", `TMR_OFS_FLAG, 8'h20);
        rc16("cap filt", `TMR_OFS_CAP_L, 16'h0999);
        $display("test capture done");
        wr(`TMR_OFS_CTL2, 8'h00);
        wr(`TMR_OFS_CTL1, 8'h50);
        wr(`TMR_OFS_CTL3, 8'hc0);
        tick(3);
        check("wave a", 16'h0001, {15'h0, waveOutA});
        check("wave b", 16'h0001, {15'h0, waveOutB});
        rc("ctl3", `TMR_OFS_CTL3, 8'h00);
        $display("test force done");
        wr(`TMR_OFS_CTL1, 8'h00);
        wr(`TMR_OFS_CTL2, 8'h08);
        i_host.wr16(`TMR_OFS_CMPA_L, 16'h0040);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h0000);
        wr(`TMR_OFS_CTL2, 8'h09);
        tick(300);
        wr(`TMR_OFS_CTL2, 8'h08);
        i_host.rd16(`TMR_OFS_CNT_L, v);
        check("ctc top", 16'h0001, {15'h0, v <= 16'h0040});
        wr(`TMR_OFS_CTL1, 8'h01);
        wr(`TMR_OFS_FLAG, 8'h27);
        wr(`TMR_OFS_CTL2, 8'h09);
        tick(600);
        wr(`TMR_OFS_CTL2, 8'h08);
        i_host.rd16(`TMR_OFS_CNT_L, v);
        check("fast top", 16'h0001, {15'h0, v <= `TMR_TOP8});
        rc("fast flags", `TMR_OFS_FLAG, 8'h07);
        // phase kind 1: up to 0xff then down, no overflow before bottom
        wr(`TMR_OFS_CTL2, 8'h00);
        i_host.wr16(`TMR_OFS_CNT_L, 16'h0000);
        wr(`TMR_OFS_FLAG, 8'h27);
        wr(`TMR_OFS_CTL2, 8'h01);
        tick(300);
        wr(`TMR_OFS_CTL2, 8'h00);
        i_host.rd16(`TMR_OFS_CNT_L, v);
        check("phase down", 16'h0001, {15'h0, v >= 16'h00c0 && v < `TMR_TOP8});
        rc("phase flags", `TMR_OFS_FLAG, 8'h06);
        $display("test top done");
        endSim();
    end
endmodule : sixteen_bit_timer_core_tb_top
